// *** src/tvt_consts.vh ***
// Behaviour
// RQ1 - Default vector offset is trap number times four
// RQ2 - Vector segment comes from programmable register
// RQ3 - Spacing field selects distance between vectors
// RQ4 - Hardware trap branches immediately, never masked
// RQ5 - Each hardware trap sets its own flag
// RQ6 - Trap pre-empts unless higher trap in service; code also holds a trap off while one of its own class is in service
// RQ7 - Interrupts and event transfers wait during traps
// RQ8 - Class A traps use vectors 02,04,06,08
// RQ9 - Class B traps share vector 0A
// RQ10 - Class B conditions keep distinct flags
// RQ11 - Software trap reaches any number 00..7F
// RQ12 - Subchannel end raises node 6F
// RQ13 - Node requests interrupt or transfer per control
// RQ14 - Software clears trap flags itself
`ifndef TVT_CONSTS_VH
`define TVT_CONSTS_VH
// ----------------------------------------
// Trap numbers
// ----------------------------------------
`define TVT_TN_RESET      7'h00
`define TVT_TN_SR0        7'h02
`define TVT_TN_STACK_OVER_FLAG      7'h04
`define TVT_TN_STACK_UNDER_FLAG      7'h06
`define TVT_TN_SBRK       7'h08
`define TVT_TN_CLASSB     7'h0A
`define TVT_TN_SUBEND     7'h6F
// ----------------------------------------
// Trap flag bit positions
// ----------------------------------------
`define TVT_F_SR0         0
`define TVT_F_STACK_OVER_FLAG       1
`define TVT_F_STACK_UNDER_FLAG       2
`define TVT_F_SBRK        3
`define TVT_F_SR1         4
`define TVT_F_UNDEFINED_OPCODE_FLAG      5
`define TVT_F_ACCERR      6
`define TVT_F_PROTECTED_INSTR_FAULT_FLAG      7
`define TVT_F_ILLEGAL_WORD_OPERAND_FLAG      8
`define TVT_NFLAGS        9
// ----------------------------------------
// Reset values and spacing codes
// ----------------------------------------
`define TVT_FLAGS_RST     9'h000
`define TVT_SEG_RST       8'h00
`define TVT_SPC_RST       2'h0
`define TVT_SPC_4         2'h0
`define TVT_SPC_8         2'h1
`define TVT_SPC_16        2'h2
`define TVT_SPC_2         2'h3
`define TVT_PRIO_TRAP     2'h3
`define TVT_PRIO_CLASSB   2'h2
`define TVT_PRIO_NONE     2'h0
`endif

// *** src/tvt_vec_calc.v ***
`default_nettype none
`include "tvt_consts.vh"
module tvt_vec_calc (
    input  wire [6:0] trap_num,
    input  wire [1:0] spacing,
    output reg  [9:0] offset
);
    // --------------------------------
    // Offset from trap number and spacing
    // --------------------------------
    always @* begin
        case (spacing)
            `TVT_SPC_4:  offset = {1'h0, trap_num, 2'h0};    // [RQ1] [RQ3]
            `TVT_SPC_8:  offset = {trap_num, 3'h0};          // [RQ3]
            `TVT_SPC_16: offset = {trap_num[5:0], 4'h0};     // [RQ3]
            default:     offset = {2'h0, trap_num, 1'h0};    // [RQ3]
        endcase
    end
endmodule // tvt_vec_calc
`default_nettype wire

// *** src/tvt_trap_unit.v ***
`default_nettype none
`include "tvt_consts.vh"
module tvt_trap_unit (
    input  wire        ref_clk,
    input  wire        rst,
    // Software set of segment and spacing
    input  wire        seg_wr,
    input  wire [7:0]  seg_wdata,
    input  wire        spc_wr,
    input  wire [1:0]  spc_wdata,
    // Hardware trap conditions, one-cycle pulses
    input  wire [8:0]  trap_cond,
    // Software clear of flags, one bit per flag
    input  wire [8:0]  flag_clr,
    // Software trap instruction
    input  wire        sw_trap,
    input  wire [6:0]  sw_trap_num,
    // Node request and its control
    input  wire        node_req,
    input  wire [6:0]  node_num,
    input  wire        node_use_xfer,
    input  wire        subch_end,
    input  wire        subch_use_xfer,
    // Return from service routine
    input  wire        svc_return,
    // Outputs to program flow
    output reg         branch_r,
    output reg  [17:0] vector_addr_r,
    output reg  [6:0]  vector_num_r,
    output reg         xfer_req_r,
    output reg  [6:0]  xfer_node_r,
    output reg  [8:0]  trap_flag_reg,
    output reg  [7:0]  vector_segment_reg,
    output reg  [1:0]  vector_spacing_field,
    output reg         trap_active_r
);
    // --------------------------------
    // Internal state
    // --------------------------------
    reg  [1:0] prio_r;          // Priority of trap in service
    reg  [1:0] prio_nxt;        // Priority of new trap
    reg  [6:0] sel_num;         // Chosen vector number
    reg        take;            // Branch this cycle
    reg        is_trap;         // Chosen source is a hardware trap
    wire [9:0] offset;          // Scaled offset
    wire       class_a;         // Any class A condition
    wire       class_b;         // Any class B condition

    // --------------------------------
    // Class decode
    // --------------------------------
    // Low four bits are class A, upper five class B
    assign class_a = |trap_cond[3:0];
    assign class_b = |trap_cond[8:4];

    // --------------------------------
    // Offset calculator
    // --------------------------------
    tvt_vec_calc u_calc (
        .trap_num (sel_num),
        .spacing  (vector_spacing_field),
        .offset   (offset)
    );

    // --------------------------------
    // Source selection
    // --------------------------------
    // Highest pending source wins; one branch per cycle
    always @* begin
        // Defaults: no branch, level unchanged
        take = 1'b0;
        is_trap = 1'b0;
        sel_num = `TVT_TN_RESET;
        prio_nxt = prio_r;
        // Class A: unmasked, held off only by class A service
        if (class_a && prio_r < `TVT_PRIO_TRAP) begin        // [RQ4] [RQ6]
            take = 1'b1;
            is_trap = 1'b1;
            prio_nxt = `TVT_PRIO_TRAP;
            // Fixed order inside class A
            if (trap_cond[`TVT_F_SR0])
                sel_num = `TVT_TN_SR0;                        // [RQ8]
            else if (trap_cond[`TVT_F_STACK_OVER_FLAG])
                sel_num = `TVT_TN_STACK_OVER_FLAG;                      // [RQ8]
            else if (trap_cond[`TVT_F_STACK_UNDER_FLAG])
                sel_num = `TVT_TN_STACK_UNDER_FLAG;                      // [RQ8]
            else
                sel_num = `TVT_TN_SBRK;                       // [RQ8]
        // Class B: shared vector, held off by any trap service
        end else if (class_b && prio_r < `TVT_PRIO_CLASSB) begin // [RQ6]
            take = 1'b1;
            is_trap = 1'b1;
            prio_nxt = `TVT_PRIO_CLASSB;
            sel_num = `TVT_TN_CLASSB;                         // [RQ9]
        // Ordinary sources only outside trap service
        end else if (prio_r == `TVT_PRIO_NONE) begin          // [RQ7]
            // Software trap, any number
            if (sw_trap) begin
                take = 1'b1;
                sel_num = sw_trap_num;                        // [RQ11]
            // Subchannel end served as interrupt
            end else if (subch_end && !subch_use_xfer) begin
                take = 1'b1;
                sel_num = `TVT_TN_SUBEND;                     // [RQ12]
            // Node served as interrupt
            end else if (node_req && !node_use_xfer) begin
                take = 1'b1;
                sel_num = node_num;                           // [RQ13]
            end
        end
    end

    // --------------------------------
    // Trap flags
    // --------------------------------
    // Sticky flags; a new trap beats a clear in one cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            trap_flag_reg <= `TVT_FLAGS_RST;
        end else begin
            // Set wins over clear
            trap_flag_reg <= (trap_flag_reg & ~flag_clr) | trap_cond; // [RQ5] [RQ10] [RQ14]
        end
    end

    // --------------------------------
    // Vector table configuration
    // --------------------------------
    // Segment and spacing written by software
    always @(posedge ref_clk) begin
        if (rst) begin
            vector_segment_reg <= `TVT_SEG_RST;
            vector_spacing_field <= `TVT_SPC_RST;
        end else begin
            // Segment write
            if (seg_wr)
                vector_segment_reg <= seg_wdata;              // [RQ2]
            // Spacing write
            if (spc_wr)
                vector_spacing_field <= spc_wdata;            // [RQ3]
        end
    end

    // --------------------------------
    // Branch output
    // --------------------------------
    // Branch pulse with vector address and number
    always @(posedge ref_clk) begin
        if (rst) begin
            branch_r <= 1'b0;
            vector_addr_r <= 18'h00000;
            vector_num_r <= 7'h00;
        end else begin
            // Pulse for one cycle
            branch_r <= take;
            // Vector held until next branch
            if (take) begin
                vector_addr_r <= {vector_segment_reg, offset}; // [RQ2]
                vector_num_r <= sel_num;
            end
        end
    end

    // --------------------------------
    // Transfer requests
    // --------------------------------
    // Event transfers, held back during trap service
    always @(posedge ref_clk) begin
        if (rst) begin
            xfer_req_r <= 1'b0;
            xfer_node_r <= 7'h00;
        end else begin
            // Default: no request
            xfer_req_r <= 1'b0;
            // Only outside traps and when no branch is taken
            if (prio_r == `TVT_PRIO_NONE && !take) begin      // [RQ7]
                // Subchannel end first
                if (subch_end && subch_use_xfer) begin
                    xfer_req_r <= 1'b1;                       // [RQ12]
                    xfer_node_r <= `TVT_TN_SUBEND;
                // Then an ordinary node
                end else if (node_req && node_use_xfer) begin
                    xfer_req_r <= 1'b1;                       // [RQ13]
                    xfer_node_r <= node_num;
                end
            end
        end
    end

    // --------------------------------
    // Trap service level
    // --------------------------------
    // Raised on trap entry, dropped by return
    always @(posedge ref_clk) begin
        if (rst) begin
            prio_r <= `TVT_PRIO_NONE;
            trap_active_r <= 1'b0;
        end else begin
            // Entry of a hardware trap
            if (take && is_trap) begin
                prio_r <= prio_nxt;
                trap_active_r <= 1'b1;
            // Return ends service; nesting not tracked
            end else if (svc_return) begin
                prio_r <= `TVT_PRIO_NONE;
                trap_active_r <= 1'b0;
            end
        end
    end
endmodule // tvt_trap_unit
`default_nettype wire

// *** verif/tvt_trap_unit_assertions.sv ***
`default_nettype none
module tvt_trap_unit_assertions (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [8:0]  trap_cond,
    input wire logic        sw_trap,
    input wire logic        svc_return,
    input wire logic        branch_r,
    input wire logic [17:0] vector_addr_r,
    input wire logic [6:0]  vector_num_r,
    input wire logic        xfer_req_r,
    input wire logic [8:0]  trap_flag_reg,
    input wire logic [1:0]  vector_spacing_field,
    input wire logic        trap_active_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Class A or class B trap raised while idle
    sequence cls_a; trap_cond[3:0] != 4'h0 && !trap_active_r && !svc_return; endsequence
    sequence cls_b; trap_cond[3:0] == 4'h0 && trap_cond[8:4] != 5'h00 && !trap_active_r; endsequence
    a_trap_taken: assert property (cls_a |=> branch_r && trap_active_r)
        else $error("trap not taken");
    a_sr0_first: assert property (cls_a ##0 trap_cond[0] |=> vector_num_r == 7'h02)
        else $error("bad class A vector");
    a_class_b_vec: assert property (cls_b ##0 !svc_return |=> branch_r && vector_num_r == 7'h0A)
        else $error("bad class B vector");
    a_flag_set: assert property (trap_cond != 9'h000 |=> (trap_flag_reg & $past(trap_cond)) == $past(trap_cond))
        else $error("flag not set");
    a_held_off: assert property (trap_active_r && !svc_return && trap_cond == 9'h000 |=> !branch_r && !xfer_req_r)
        else $error("request during trap");
    a_sw_taken: assert property (sw_trap && trap_cond == 9'h000 && !trap_active_r |=> branch_r)
        else $error("software trap lost");
    a_gap_four: assert property (branch_r && vector_spacing_field == 2'h0 && $stable(vector_spacing_field) |-> vector_addr_r[9:0] == {1'b0, vector_num_r, 2'b00})
        else $error("bad default offset");
    a_ret_idle: assert property (svc_return && trap_cond == 9'h000 |=> !trap_active_r)
        else $error("trap level stuck");
endmodule // tvt_trap_unit_assertions
bind tvt_trap_unit tvt_trap_unit_assertions chk_u (.ref_clk, .rst, .trap_cond, .sw_trap,
    .svc_return, .branch_r, .vector_addr_r, .vector_num_r, .xfer_req_r, .trap_flag_reg,
    .vector_spacing_field, .trap_active_r);
`default_nettype wire

// *** verif/tvt_cpu_flow.sv ***
`default_nettype none
module tvt_cpu_flow (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [3:0] svc_len,
    input  wire logic       branch_r,
    input  wire logic       trap_active_r,
    output var  logic       svc_return,
    output var  logic [8:0] flag_clr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left_r; // Handler cycles left
    initial {svc_return, flag_clr} = '0;
    // Handler runs svc_len cycles, then clears all flags and returns in the same cycle
    always @(posedge ref_clk) begin
        svc_return <= 1'b0;
        flag_clr <= 9'h000;
        if (rst) left_r <= 4'h0;
        else if (branch_r && trap_active_r) left_r <= svc_len;
        else if (left_r == 4'h1) begin
            left_r <= 4'h0;
            svc_return <= 1'b1;
            flag_clr <= 9'h1FF;
        end else if (left_r != 4'h0) left_r <= left_r - 4'h1;
    end
endmodule // tvt_cpu_flow
`default_nettype wire

// *** verif/tvt_trap_unit_test.sv ***
`default_nettype none
module tvt_trap_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [8:0] tc;
        logic [1:0] kd;
        logic [6:0] num;
        logic [6:0] en;
        logic [9:0] eo;
    } tvt_row_t;
    logic ref_clk = 0, rst = 1, seg_wr = 0, spc_wr = 0, sw_trap = 0, svc_return, branch_r;
    logic node_req = 0, node_use_xfer = 0, subch_end = 0, subch_use_xfer = 0;
    logic xfer_req_r, trap_active_r;
    logic [7:0] seg_wdata = 8'h00, vector_segment_reg;
    logic [1:0] spc_wdata = 2'h0, vector_spacing_field;
    logic [3:0] svc_len = 4'h1;
    logic [8:0] trap_cond = 9'h000, flag_clr, trap_flag_reg;
    logic [6:0] sw_trap_num = 7'h00, node_num = 7'h00, vector_num_r, xfer_node_r;
    logic [17:0] vector_addr_r;
    int n_fail = 0, samples_checked = 0, i;
    tvt_row_t rows [13] = '{'{9'h001, 0, 0, 7'h02, 10'h008}, '{9'h002, 0, 0, 7'h04, 10'h010},
        '{9'h004, 0, 0, 7'h06, 10'h018}, '{9'h008, 0, 0, 7'h08, 10'h020},
        '{9'h010, 0, 0, 7'h0A, 10'h028}, '{9'h020, 0, 0, 7'h0A, 10'h028},
        '{9'h040, 0, 0, 7'h0A, 10'h028}, '{9'h080, 0, 0, 7'h0A, 10'h028},
        '{9'h100, 0, 0, 7'h0A, 10'h028}, '{9'h1FF, 0, 0, 7'h02, 10'h008},
        '{9'h000, 1, 7'h7F, 7'h7F, 10'h1FC}, '{9'h000, 2, 0, 7'h6F, 10'h1BC},
        '{9'h000, 3, 7'h43, 7'h43, 10'h10C}};
    always #4 ref_clk = ~ref_clk;
    tvt_trap_unit dut_u (.ref_clk, .rst, .seg_wr, .seg_wdata, .spc_wr, .spc_wdata, .trap_cond,
        .flag_clr, .sw_trap, .sw_trap_num, .node_req, .node_num, .node_use_xfer, .subch_end,
        .subch_use_xfer, .svc_return, .branch_r, .vector_addr_r, .vector_num_r, .xfer_req_r,
        .xfer_node_r, .trap_flag_reg, .vector_segment_reg, .vector_spacing_field, .trap_active_r);
    tvt_cpu_flow cpu_u (.ref_clk, .rst, .svc_len, .branch_r, .trap_active_r, .svc_return,
        .flag_clr);
    task automatic wrap_up;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge ref_clk);
        #1;
    endtask
    // Wait for the handler to return, bounded
    task automatic idle;
        for (i = 0; i < 30 && trap_active_r !== 1'b0; i++) step;
        if (i == 30) begin
            n_fail++;
            wrap_up;
        end
    endtask
    // One-cycle request of the given kind
    task automatic fire(input logic [8:0] tc, input logic [1:0] kd, input logic [6:0] num);
        trap_cond = tc;
        sw_trap = (kd == 2'h1);
        subch_end = (kd == 2'h2);
        node_req = (kd == 2'h3);
        sw_trap_num = num;
        node_num = num;
        step;
        {trap_cond, sw_trap, subch_end, node_req} = '0;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk({trap_flag_reg, vector_segment_reg, trap_active_r}, 18'h00000);
        chk({branch_r, xfer_req_r, vector_num_r, vector_spacing_field}, 18'h00000);
        chk(vector_addr_r, 18'h00000);
        foreach (rows[k]) begin
            fire(rows[k].tc, rows[k].kd, rows[k].num);
            chk(branch_r, 1);
            chk(vector_addr_r, {8'h00, rows[k].eo});
            chk(vector_num_r, rows[k].en);
            chk(trap_flag_reg, rows[k].tc);
            idle;
        end
        seg_wr = 1;
        seg_wdata = 8'hA5;
        for (int s = 1; s < 5; s++) begin
            spc_wr = 1;
            spc_wdata = s[1:0];
            step;
            {seg_wr, spc_wr} = '0;
            fire(0, 1, 7'h10);
            chk(vector_addr_r, {8'hA5, 10'h010 << (s[1:0] == 3 ? 1 : s[1:0] + 2)});
        end
        svc_len = 4'hC;
        node_use_xfer = 1;
        fire(9'h010, 0, 0);
        fire(0, 1, 7'h20);
        chk(branch_r, 0);
        fire(0, 3, 7'h43);
        chk(xfer_req_r, 0);
        fire(9'h020, 0, 0);
        chk({branch_r, trap_flag_reg}, 10'h030);
        fire(9'h002, 0, 0);
        chk({branch_r, vector_num_r}, 8'h84);
        idle;
        fire(0, 3, 7'h43);
        chk({xfer_req_r, xfer_node_r, branch_r}, 9'h186);
        chk(trap_flag_reg, 9'h000);
        subch_use_xfer = 1;
        fire(0, 2, 0);
        chk({xfer_req_r, xfer_node_r, branch_r}, 9'h1DE);
        wrap_up;
    end
endmodule // tvt_trap_unit_test
`default_nettype wire
